/* dv/shhp_host.sv */
// Host model: drives strobe, direction and data pins of the handshake port.
// Assumes the bench raises go for one cycle and waits for done.
`timescale 1ns/1ps
`default_nettype none
module shhp_host (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       rd,
  input  wire logic [3:0] slow,
  input  wire logic [7:0] wdata,
  input  wire logic       in_rdy,
  input  wire logic       out_rdy,
  input  wire logic [7:0] dev_data,
  input  wire logic [7:0] dev_oe_b,
  output logic            strobe_b,
  output logic            dir,
  output logic      [7:0] bus,
  output logic      [7:0] rdata,
  output logic            done
);
  logic       drv;
  logic [7:0] hval;
  // Starts at a known level so the idle toggling is visible from time zero
  logic [7:0] last = 8'h00;
  int         n;
  // Undriven bus toggles each cycle so a stale byte never reads as valid
  assign bus = !dev_oe_b[0] ? dev_data : drv ? hval : ~last;
  always @(negedge clk) last <= bus;
  initial begin
    strobe_b = 1'b1;
    dir = 1'b0;
    drv = 1'b0;
    hval = 8'h00;
    rdata = 8'h00;
    done = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        done = 1'b0;
        n = 0;
        @(negedge clk);
        while ((rd ? out_rdy : in_rdy) !== 1'b0 && n < 20) begin
          @(negedge clk);
          n++;
        end
        dir = rd;
        repeat (2) @(negedge clk);
        strobe_b = 1'b0;
        @(negedge clk);
        hval = wdata;
        drv = !rd;
        n = 0;
        while (rd && dev_oe_b !== 8'h00 && n < 12) begin
          @(negedge clk);
          n++;
        end
        repeat (6 + slow) @(negedge clk);
        rdata = bus;
        strobe_b = 1'b1;
        repeat (8) @(negedge clk);
        drv = 1'b0;
        done = 1'b1;
      end
    end
  end
endmodule : shhp_host
`default_nettype wire

/* dv/tb_shhp_port.sv */
// Self-checking bench for the handshake port with a host model.
// Assumes the design files and shhp_host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_shhp_port;
  logic       clk, rst_b, mode, arm0, arm1, go, rd, rx_ready, done;
  logic       r0, r0_oe_b, r1, r1_oe_b, strobe_b, dir, rx_valid, wirq, rirq, r0_p, r1_p;
  logic [1:0] g_out, g_oe_b, pin_lvl;
  logic [3:0] slow;
  logic [7:0] wdata, tx_byte, bus, d_out, d_oe_b, rx_byte, rdata;
  int         n_fail, compares, n_wirq, n_rirq, cyc;

  shhp_port u_shhp_port (.clk(clk), .rst_b(rst_b), .mode_select_bit(mode),
    .port_d_bit0_arm(arm0), .port_d_bit1_arm(arm1), .gpio_d_out(g_out),
    .gpio_d_oe_b(g_oe_b), .port_d_bit0_out(r0), .port_d_bit0_oe_b(r0_oe_b),
    .port_d_bit1_out(r1), .port_d_bit1_oe_b(r1_oe_b), .port_d_bit2(strobe_b),
    .port_d_bit3(dir), .port_d_pin_level(pin_lvl), .host_data_in(bus),
    .host_data_out(d_out), .host_data_oe_b(d_oe_b), .tx_byte(tx_byte),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .write_done_interrupt(wirq), .read_done_interrupt(rirq));
  shhp_host u_shhp_host (.clk(clk), .go(go), .rd(rd), .slow(slow), .wdata(wdata),
    .in_rdy(r0), .out_rdy(r1), .dev_data(d_out), .dev_oe_b(d_oe_b),
    .strobe_b(strobe_b), .dir(dir), .bus(bus), .rdata(rdata), .done(done));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Ready must stay high while the software bit is high
  task automatic arm_path(input logic b);
    @(negedge clk);
    if (b) arm1 = 1'b1; else arm0 = 1'b1;
    @(negedge clk);
    check(8'(b ? r1 : r0), 8'h01);
    if (b) arm1 = 1'b0; else arm0 = 1'b0;
    @(negedge clk);
  endtask : arm_path

  task automatic host(input logic r, input logic [7:0] d, input logic [3:0] s);
    int n;
    @(negedge clk);
    go = 1'b1;
    rd = r;
    wdata = d;
    slow = s;
    @(negedge clk);
    go = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) n_fail++;
  endtask : host

  // A clock edge passes with ready low so back-to-back pops never retoggle it at once
  task automatic pop(input logic [7:0] exp);
    check(8'(rx_valid), 8'h01);
    check(rx_byte, exp);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask : pop

  // ****************************************************************
  // Monitors
  // ****************************************************************
  always @(posedge clk) begin
    if (rst_b === 1'b1 && wirq === 1'b1) begin
      n_wirq++;
      check(8'({r0_p, r0}), 8'h01);
    end
    if (rst_b === 1'b1 && rirq === 1'b1) begin
      n_rirq++;
      check(8'({r1_p, r1}), 8'h01);
    end
    r0_p <= r0;
    r1_p <= r1;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_write();
    arm_path(1'b0);
    check(8'(r0), 8'h00);
    host(1'b0, 8'ha5, 4'h0);
    check(8'(r0), 8'h01);
    check(n_wirq[7:0], 8'h01);
    check(8'(pin_lvl), 8'h01);
    pop(8'ha5);
    check(8'(rx_valid), 8'h00);
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    tx_byte = 8'h3c;
    arm_path(1'b1);
    check(8'(r1), 8'h00);
    tx_byte = 8'hff;
    host(1'b1, 8'h00, 4'h3);
    check(rdata, 8'h3c);
    check(d_oe_b, 8'hff);
    check(8'(r1), 8'h01);
    check(8'(pin_lvl), 8'h03);
    check(n_rirq[7:0], 8'h01);
    $display("test read done");
  endtask : t_read

  // A strobe with the read direction must not finish a pending write
  task automatic t_wrong_dir();
    arm_path(1'b0);
    host(1'b1, 8'h00, 4'h0);
    check(8'(r0), 8'h00);
    check(n_wirq[7:0], 8'h01);
    check(8'(rx_valid), 8'h00);
    check(d_oe_b, 8'hff);
    host(1'b0, 8'h5a, 4'h2);
    check(n_wirq[7:0], 8'h02);
    pop(8'h5a);
    $display("test wrong direction done");
  endtask : t_wrong_dir

  // Fill the receive buffer while the processor stalls, then drain it
  task automatic t_fifo();
    for (int i = 0; i < 16; i++) begin
      arm_path(1'b0);
      host(1'b0, 8'h10 + 8'(i), 4'h0);
    end
    arm_path(1'b0);
    check(8'(r0), 8'h01);
    for (int i = 0; i < 16; i++) pop(8'h10 + 8'(i));
    check(8'(r0), 8'h00);
    host(1'b0, 8'hee, 4'h1);
    pop(8'hee);
    check(n_wirq[7:0], 8'h13);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_master();
    mode = 1'b1;
    g_out = 2'b01;
    g_oe_b = 2'b10;
    repeat (2) @(negedge clk);
    check(8'({r1, r1_oe_b, r0, r0_oe_b}), 8'h06);
    arm_path(1'b0);
    mode = 1'b0;
    repeat (2) @(negedge clk);
    check(8'({r1, r0, r0_oe_b}), 8'h06);
    $display("test master done");
  endtask : t_master

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {rst_b, mode, arm0, arm1, go, rd, rx_ready} = 7'h00;
    {g_out, g_oe_b, slow} = 8'h00;
    {wdata, tx_byte} = 16'h0000;
    {n_fail, compares, n_wirq, n_rirq, cyc} = '0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check(8'({r1, r0, r1_oe_b, r0_oe_b}), 8'h0c);
    check(d_oe_b, 8'hff);
    check(8'({wirq, rirq, rx_valid}), 8'h00);
    repeat (4) @(negedge clk);
    $display("test reset done");
    t_write();
    t_read();
    t_wrong_dir();
    t_fifo();
    t_master();
    print_verdict();
  end
endmodule : tb_shhp_port
`default_nettype wire

/* logic/shhp_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides; DEPTH must be a power of two.
// Assumes one clock; push and pop may happen in the same cycle.

`timescale 1ns/1ps
`default_nettype none

module shhp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Storage holds data only, so it needs no reset
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : shhp_fifo

`default_nettype wire

/* logic/shhp_pkg.sv */
// Constants, state encodings and timing figures of the slave host handshake port.
// Assumes a single 20 MHz processor clock and a synchronous active-low reset.

package shhp_pkg;

  // ***********************************************************************
  // Widths and structure
  // ***********************************************************************
  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int SYNC_W      = DATA_W + 2;
  localparam int SYNC_STROBE = DATA_W;
  localparam int SYNC_DIR    = DATA_W + 1;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RESET_LOW_NS    = 100;
  localparam int RESET_LOW_CYC   = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EDGE_HOLD_CPU   = 2;

  // ***********************************************************************
  // Levels and reset values
  // ***********************************************************************
  localparam logic DIR_WRITE   = 1'h0;
  localparam logic DIR_READ    = 1'h1;
  localparam logic MODE_SLAVE  = 1'h0;
  localparam logic READY_IDLE  = 1'h1;
  localparam logic READY_BUSY  = 1'h0;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_INIT  = 10'h3ff;

  // ***********************************************************************
  // State machines
  // ***********************************************************************
  typedef enum logic [2:0] {
    WR_IDLE  = 3'h1,
    WR_ARMED = 3'h2,
    WR_LATCH = 3'h4
  } shhp_wr_e;

  typedef enum logic [2:0] {
    RD_IDLE  = 3'h1,
    RD_ARMED = 3'h2,
    RD_DRIVE = 3'h4
  } shhp_rd_e;

endpackage : shhp_pkg

/* logic/shhp_port.sv */
// Slave host handshake port: byte transfers between a host and the processor.
// Assumes the processor side sits on clk; host pins are asynchronous.

`timescale 1ns/1ps
`default_nettype none

module shhp_port (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          mode_select_bit,
  input  wire logic                          port_d_bit0_arm,
  input  wire logic                          port_d_bit1_arm,
  input  wire logic [1:0]                    gpio_d_out,
  input  wire logic [1:0]                    gpio_d_oe_b,
  output logic                               port_d_bit0_out,
  output logic                               port_d_bit0_oe_b,
  output logic                               port_d_bit1_out,
  output logic                               port_d_bit1_oe_b,
  input  wire logic                          port_d_bit2,
  input  wire logic                          port_d_bit3,
  output logic      [1:0]                    port_d_pin_level,
  input  wire logic [shhp_pkg::DATA_W-1:0]   host_data_in,
  output logic      [shhp_pkg::DATA_W-1:0]   host_data_out,
  output logic      [shhp_pkg::DATA_W-1:0]   host_data_oe_b,
  input  wire logic [shhp_pkg::DATA_W-1:0]   tx_byte,
  output logic      [shhp_pkg::DATA_W-1:0]   rx_byte,
  output logic                               rx_valid,
  input  wire logic                          rx_ready,
  output logic                               write_done_interrupt,
  output logic                               read_done_interrupt
);

  logic [shhp_pkg::SYNC_W-1:0] sync_lvl;
  logic                        strobe_lvl;
  logic                        dir_lvl;
  logic [shhp_pkg::DATA_W-1:0] data_lvl;
  logic                        slave;
  logic                        fifo_in_valid;
  logic                        fifo_in_ready;

  // ***********************************************************************
  // Pin synchronisation
  // ***********************************************************************
  shhp_sync #(
    .W    (shhp_pkg::SYNC_W),
    .INIT (shhp_pkg::SYNC_INIT)
  ) u_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .async_in  ({port_d_bit3, port_d_bit2, host_data_in}),
    .level_out (sync_lvl)
  );

  // Data passes the same filter as the strobe, so both stay aligned
  assign strobe_lvl       = sync_lvl[shhp_pkg::SYNC_STROBE];
  assign dir_lvl          = sync_lvl[shhp_pkg::SYNC_DIR];
  assign data_lvl         = sync_lvl[shhp_pkg::DATA_W-1:0];
  assign port_d_pin_level = {dir_lvl, strobe_lvl};
  assign slave            = (mode_select_bit == shhp_pkg::MODE_SLAVE);

  // ***********************************************************************
  // Edge detection
  // ***********************************************************************
  logic strobe_prev_q, strobe_prev_d;
  logic arm0_prev_q, arm0_prev_d;
  logic arm1_prev_q, arm1_prev_d;
  logic str_fall, str_rise;
  logic arm_in_fall, arm_out_fall;

  always_comb begin
    strobe_prev_d = strobe_lvl;
    arm0_prev_d   = port_d_bit0_arm;
    arm1_prev_d   = port_d_bit1_arm;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strobe_prev_q <= shhp_pkg::READY_IDLE;
      arm0_prev_q   <= 1'h0;
      arm1_prev_q   <= 1'h0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      arm0_prev_q   <= arm0_prev_d;
      arm1_prev_q   <= arm1_prev_d;
    end
  end

  assign str_fall     = strobe_prev_q && !strobe_lvl;
  assign str_rise     = !strobe_prev_q && strobe_lvl;
  assign arm_in_fall  = arm0_prev_q && !port_d_bit0_arm;
  assign arm_out_fall = arm1_prev_q && !port_d_bit1_arm;

  // ***********************************************************************
  // Host write path
  // ***********************************************************************
  shhp_pkg::shhp_wr_e wr_q, wr_d;
  logic               input_ready_q, input_ready_d;
  logic               wr_irq_q, wr_irq_d;
  logic               arm_in_pend_q, arm_in_pend_d;
  logic               arm_in_req;

  // An arm is held pending while the FIFO is full rather than lost
  assign arm_in_req = arm_in_fall || arm_in_pend_q;

  always_comb begin
    wr_d          = wr_q;
    input_ready_d = input_ready_q;
    wr_irq_d      = 1'h0;
    arm_in_pend_d = arm_in_pend_q;
    fifo_in_valid = 1'h0;
    case (wr_q)
      shhp_pkg::WR_IDLE: begin
        arm_in_pend_d = slave && arm_in_req && !fifo_in_ready;
        if (slave && arm_in_req && fifo_in_ready) begin
          wr_d          = shhp_pkg::WR_ARMED;
          input_ready_d = shhp_pkg::READY_BUSY;
        end
      end
      shhp_pkg::WR_ARMED: begin
        if (str_fall && dir_lvl == shhp_pkg::DIR_WRITE) begin
          wr_d = shhp_pkg::WR_LATCH;
        end
      end
      shhp_pkg::WR_LATCH: begin
        if (str_rise) begin
          fifo_in_valid = 1'h1;
          wr_d          = shhp_pkg::WR_IDLE;
          input_ready_d = shhp_pkg::READY_IDLE;
          wr_irq_d      = 1'h1;
        end
      end
      default: begin
        wr_d          = shhp_pkg::WR_IDLE;
        input_ready_d = shhp_pkg::READY_IDLE;
      end
    endcase
    // Leaving slave mode abandons a transfer silently
    if (!slave) begin
      wr_d          = shhp_pkg::WR_IDLE;
      input_ready_d = shhp_pkg::READY_IDLE;
      wr_irq_d      = 1'h0;
      arm_in_pend_d = 1'h0;
      fifo_in_valid = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q          <= shhp_pkg::WR_IDLE;
      input_ready_q <= shhp_pkg::READY_IDLE;
      wr_irq_q      <= 1'h0;
      arm_in_pend_q <= 1'h0;
    end else begin
      wr_q          <= wr_d;
      input_ready_q <= input_ready_d;
      wr_irq_q      <= wr_irq_d;
      arm_in_pend_q <= arm_in_pend_d;
    end
  end

  // Room is checked at arm time, so the push below is never refused
  shhp_fifo #(
    .W     (shhp_pkg::DATA_W),
    .DEPTH (shhp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (data_lvl),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_byte)
  );

  // ***********************************************************************
  // Host read path
  // ***********************************************************************
  shhp_pkg::shhp_rd_e          rd_q, rd_d;
  logic                        output_ready_q, output_ready_d;
  logic                        rd_irq_q, rd_irq_d;
  logic                        drive_q, drive_d;
  logic [shhp_pkg::DATA_W-1:0] out_byte_q, out_byte_d;

  always_comb begin
    rd_d           = rd_q;
    output_ready_d = output_ready_q;
    rd_irq_d       = 1'h0;
    drive_d        = drive_q;
    out_byte_d     = out_byte_q;
    case (rd_q)
      shhp_pkg::RD_IDLE: begin
        if (slave && arm_out_fall) begin
          out_byte_d     = tx_byte;
          rd_d           = shhp_pkg::RD_ARMED;
          output_ready_d = shhp_pkg::READY_BUSY;
        end
      end
      shhp_pkg::RD_ARMED: begin
        if (str_fall && dir_lvl == shhp_pkg::DIR_READ) begin
          rd_d    = shhp_pkg::RD_DRIVE;
          drive_d = 1'h1;
        end
      end
      shhp_pkg::RD_DRIVE: begin
        if (str_rise) begin
          rd_d           = shhp_pkg::RD_IDLE;
          drive_d        = 1'h0;
          output_ready_d = shhp_pkg::READY_IDLE;
          rd_irq_d       = 1'h1;
        end
      end
      default: begin
        rd_d           = shhp_pkg::RD_IDLE;
        drive_d        = 1'h0;
        output_ready_d = shhp_pkg::READY_IDLE;
      end
    endcase
    if (!slave) begin
      rd_d           = shhp_pkg::RD_IDLE;
      drive_d        = 1'h0;
      output_ready_d = shhp_pkg::READY_IDLE;
      rd_irq_d       = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_q           <= shhp_pkg::RD_IDLE;
      output_ready_q <= shhp_pkg::READY_IDLE;
      rd_irq_q       <= 1'h0;
      drive_q        <= 1'h0;
      out_byte_q     <= shhp_pkg::BYTE_RESET;
    end else begin
      rd_q           <= rd_d;
      output_ready_q <= output_ready_d;
      rd_irq_q       <= rd_irq_d;
      drive_q        <= drive_d;
      out_byte_q     <= out_byte_d;
    end
  end

  // ***********************************************************************
  // Pin muxing
  // ***********************************************************************
  assign host_data_out    = out_byte_q;
  assign host_data_oe_b   = {shhp_pkg::DATA_W{!drive_q}};
  assign port_d_bit0_out  = slave ? input_ready_q : gpio_d_out[0];
  assign port_d_bit0_oe_b = slave ? 1'h0 : gpio_d_oe_b[0];
  assign port_d_bit1_out  = slave ? output_ready_q : gpio_d_out[1];
  assign port_d_bit1_oe_b = slave ? 1'h0 : gpio_d_oe_b[1];

  assign write_done_interrupt = wr_irq_q;
  assign read_done_interrupt  = rd_irq_q;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_wr_end;
    wr_q == shhp_pkg::WR_LATCH && str_rise && slave;
  endsequence

  sequence s_rd_start;
    rd_q == shhp_pkg::RD_ARMED && str_fall && dir_lvl == shhp_pkg::DIR_READ && slave;
  endsequence

  sequence s_rd_end;
    rd_q == shhp_pkg::RD_DRIVE && str_rise && slave;
  endsequence

  a_arm_input: assert property (
    wr_q == shhp_pkg::WR_IDLE && slave && arm_in_req && fifo_in_ready
    |=> !input_ready_q && wr_q == shhp_pkg::WR_ARMED)
    else $error("input ready did not fall after arm");

  a_write_latch: assert property (
    s_wr_end |-> fifo_in_valid ##1 input_ready_q && write_done_interrupt)
    else $error("write end did not latch and raise input ready");

  a_write_irq: assert property (
    write_done_interrupt |-> $rose(input_ready_q) ##1 !write_done_interrupt)
    else $error("write interrupt not tied to input ready rise");

  a_arm_output: assert property (
    rd_q == shhp_pkg::RD_IDLE && slave && arm_out_fall
    |=> !output_ready_q && out_byte_q == $past(tx_byte))
    else $error("output ready did not fall with byte taken");

  a_read_drive: assert property (
    s_rd_start |=> host_data_oe_b == '0 && host_data_out == out_byte_q)
    else $error("pending byte not driven after strobe fall");

  a_read_done: assert property (
    s_rd_end |=> output_ready_q && read_done_interrupt && host_data_oe_b == '1)
    else $error("read end did not raise output ready and interrupt");

  a_pin_bit0: assert property (
    slave |-> port_d_bit0_out == input_ready_q && !port_d_bit0_oe_b)
    else $error("port d bit 0 not showing input ready");

  a_pin_bit1: assert property (
    slave |-> port_d_bit1_out == output_ready_q && !port_d_bit1_oe_b)
    else $error("port d bit 1 not showing output ready");

  a_master_idle: assert property (
    !slave |=> wr_q == shhp_pkg::WR_IDLE && rd_q == shhp_pkg::RD_IDLE && host_data_oe_b == '1)
    else $error("strobe acted on outside slave mode");

  a_reset_ready: assert property (
    $rose(rst_b) |-> input_ready_q && output_ready_q)
    else $error("ready outputs not high after reset");

  a_rx_byte: assert property (
    fifo_in_valid |-> fifo_in_ready && wr_q == shhp_pkg::WR_LATCH)
    else $error("host byte pushed without room");

  a_single_edge: assert property (
    str_rise |=> !str_rise [*3])
    else $error("one strobe rise counted twice");

endmodule : shhp_port

`default_nettype wire

/* logic/shhp_sync.sv */
// Three-stage input synchroniser with a per-bit agreement filter.
// Assumes inputs are asynchronous pins; output changes only when stages two and three agree.

`timescale 1ns/1ps
`default_nettype none

module shhp_sync #(
  parameter int          W    = 10,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;

  // ***********************************************************************
  // Agreement filter
  // ***********************************************************************
  // The first stage is read only by the second stage
  for (genvar i = 0; i < W; i++) begin : g_filt
    assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      lvl_q <= INIT;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule : shhp_sync

`default_nettype wire
